// >>> hw/dsp_status_flag_register.sv
// processor status word and access mode register with avalon-mm slave
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dsp_status_flag_register
   import status_word_pkg::*;
#(
   parameter int RES_W = status_word_pkg::DATA_W
) (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   // avalon-mm slave
   input  wire logic [status_word_pkg::ADDR_W-1:0] address,
   input  wire logic                              read,
   input  wire logic                              write,
   input  wire logic [3:0]                        byteenable,
   input  wire logic [status_word_pkg::BUS_W-1:0] writedata,
   output logic      [status_word_pkg::BUS_W-1:0] readdata,
   output logic                                   waitrequest,
   // alu result, low half real, high half imaginary or upper double word
   input  wire logic                              alu_valid,
   input  wire logic [2*RES_W-1:0]                alu_result,
   input  wire logic                              alu_carry_lo,
   input  wire logic                              alu_carry_hi,
   input  wire logic                              alu_ovf_lo,
   input  wire logic                              alu_ovf_hi,
   // multiplier, branch and load-condition events
   input  wire logic                              mul_ovf,
   input  wire logic                              branch_tests_sticky,
   input  wire logic                              load_condition_instruction,
   input  wire logic [7:0]                        load_condition_data,
   // input fifo level
   input  wire logic                              fifo_empty,
   // decoded state
   output logic      [2*RES_W-1:0]                alu_result_out,
   output logic      [15:0]                       processor_status_word,
   output logic      [1:0]                        arith_mode,
   output logic                                   clamp_enable,
   output logic                                   x_bank_wrap_flag,
   output logic                                   y_bank_wrap_flag,
   output logic      [status_word_pkg::AMC_W-1:0] access_mode_control
);
   import status_word_pkg::*;

   generate
      if (RES_W != DATA_W) begin : g_bad_width
         $error("result lane width must be 16");
      end
   endgenerate

   // condition half
   logic sign_real_flag_q;
   logic sign_imag_flag_q;
   logic carry_real_flag_q;
   logic carry_imag_flag_q;
   logic zero_flag_q;
   logic overflow_flag_q;
   logic sticky_overflow_flag_q;
   logic early_overflow_flag_q;
   logic multiplier_overflow_flag_q;
   // state half
   logic       queue_vacant_flag_q;
   logic       clamp_enable_q;
   logic [1:0] mode_q;
   logic       x_wrap_q;
   logic       y_wrap_q;
   logic [AMC_W-1:0] amc_q;

   // bus handshake
   bus_state_t                bus_state_q;
   logic                      waitrequest_q;
   logic [BUS_W-1:0]          readdata_q;
   logic                      req;
   logic                      accept;
   logic                      wr_status;
   logic                      wr_amc;
   logic [15:0]               status_word;
   logic [BUS_W-1:0]          read_mux;

   // result decode
   logic                      is_complex;
   logic                      is_double;
   logic                      res_sign_re;
   logic                      res_sign_im;
   logic                      res_zero;
   logic                      res_carry_re;
   logic                      res_carry_im;
   logic                      res_ovf;
   logic                      res_early;
   logic [RES_W-1:0]          clamped_lo;
   logic [RES_W-1:0]          clamped_hi;
   logic                      clamp_lo_on;
   logic                      clamp_hi_on;

   assign is_complex = (mode_q == MODE_COMPLEX);
   assign is_double  = (mode_q == MODE_DOUBLE);

   always_comb begin
      res_sign_re  = 1'b0;
      res_sign_im  = 1'b0;
      res_zero     = 1'b0;
      res_carry_re = 1'b0;
      res_carry_im = 1'b0;
      res_ovf      = 1'b0;
      res_early    = 1'b0;
      if (is_double) begin
         res_sign_re  = alu_result[2*RES_W-1];
         res_zero     = (alu_result == '0);
         res_carry_re = alu_carry_hi;
         res_ovf      = alu_ovf_hi;
         res_early    = alu_result[2*RES_W-1] ^ alu_result[2*RES_W-2];
      end else if (is_complex) begin
         res_sign_re  = alu_result[RES_W-1];
         res_sign_im  = alu_result[2*RES_W-1];
         res_zero     = (alu_result[RES_W-1:0] == '0) && (alu_result[2*RES_W-1:RES_W] == '0);
         res_carry_re = alu_carry_lo;
         res_carry_im = alu_carry_hi;
         res_ovf      = alu_ovf_lo | alu_ovf_hi;
         res_early    = alu_result[RES_W-1] ^ alu_result[RES_W-2];
      end else begin
         res_sign_re  = alu_result[RES_W-1];
         res_zero     = (alu_result[RES_W-1:0] == '0);
         res_carry_re = alu_carry_lo;
         res_ovf      = alu_ovf_lo;
         res_early    = alu_result[RES_W-1] ^ alu_result[RES_W-2];
      end
   end

   // sign flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sign_real_flag_q <= STATUS_RESET[BIT_SIGN_RE];
         sign_imag_flag_q <= STATUS_RESET[BIT_SIGN_IM];
      end else if (load_condition_instruction) begin
         sign_real_flag_q <= load_condition_data[7];
         sign_imag_flag_q <= load_condition_data[6];
      end else if (alu_valid) begin
         sign_real_flag_q <= res_sign_re;
         sign_imag_flag_q <= res_sign_im;
      end
   end

   // carry flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carry_real_flag_q <= STATUS_RESET[BIT_CARRY_RE];
         carry_imag_flag_q <= STATUS_RESET[BIT_CARRY_IM];
      end else if (load_condition_instruction) begin
         carry_real_flag_q <= load_condition_data[5];
         carry_imag_flag_q <= load_condition_data[4];
      end else if (alu_valid) begin
         carry_real_flag_q <= res_carry_re;
         carry_imag_flag_q <= res_carry_im;
      end
   end

   // zero and overflow flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_flag_q     <= STATUS_RESET[BIT_ZERO];
         overflow_flag_q <= STATUS_RESET[BIT_OVF];
      end else if (load_condition_instruction) begin
         zero_flag_q     <= load_condition_data[3];
         overflow_flag_q <= load_condition_data[2];
      end else if (alu_valid) begin
         zero_flag_q     <= res_zero;
         overflow_flag_q <= res_ovf;
      end
   end

   // sticky overflow: a new overflow wins over the branch-test clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sticky_overflow_flag_q <= STATUS_RESET[BIT_STICKY];
      end else if (alu_valid && res_ovf) begin
         sticky_overflow_flag_q <= 1'b1;
      end else if (branch_tests_sticky) begin
         sticky_overflow_flag_q <= 1'b0;
      end
   end

   // early overflow: held until load-condition, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         early_overflow_flag_q <= STATUS_RESET[BIT_EARLY];
      end else if (alu_valid && res_early) begin
         early_overflow_flag_q <= 1'b1;
      end else if (load_condition_instruction) begin
         early_overflow_flag_q <= 1'b0;
      end
   end

   // multiplier overflow only counts for complex multiplies
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         multiplier_overflow_flag_q <= STATUS_RESET[BIT_MUL_OVF];
      end else if (mul_ovf && is_complex) begin
         multiplier_overflow_flag_q <= 1'b1;
      end else if (load_condition_instruction) begin
         multiplier_overflow_flag_q <= 1'b0;
      end
   end

   // queue vacant mirrors the fifo
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_vacant_flag_q <= STATUS_RESET[BIT_VACANT];
      end else begin
         queue_vacant_flag_q <= fifo_empty;
      end
   end

   // bus handshake: waitrequest drops for exactly one cycle per request
   assign req    = read | write;
   assign accept = req && (bus_state_q == BUS_ANSWER);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_q   <= BUS_IDLE;
         waitrequest_q <= 1'b1;
      end else begin
         case (bus_state_q)
            BUS_IDLE: begin
               if (req) begin
                  bus_state_q   <= BUS_ANSWER;
                  waitrequest_q <= 1'b0;
               end
            end
            BUS_ANSWER: begin
               bus_state_q   <= BUS_IDLE;
               waitrequest_q <= 1'b1;
            end
            default: begin
               bus_state_q   <= BUS_IDLE;
               waitrequest_q <= 1'b1;
            end
         endcase
      end
   end

   assign wr_status = accept && write && (address == OFF_STATUS);
   assign wr_amc    = accept && write && (address == OFF_ACCESS_MODE);

   // state half: software sets clamp, mode and circular bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clamp_enable_q <= STATUS_RESET[BIT_CLAMP];
         mode_q         <= STATUS_RESET[BIT_MODE_HI:BIT_MODE_LO];
         x_wrap_q       <= STATUS_RESET[BIT_X_WRAP];
         y_wrap_q       <= STATUS_RESET[BIT_Y_WRAP];
      end else if (wr_status && byteenable[0]) begin
         clamp_enable_q <= writedata[BIT_CLAMP];
         mode_q         <= writedata[BIT_MODE_HI:BIT_MODE_LO];
         x_wrap_q       <= writedata[BIT_X_WRAP];
         y_wrap_q       <= writedata[BIT_Y_WRAP];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         amc_q <= AMC_RESET;
      end else if (wr_amc && byteenable[0]) begin
         amc_q <= writedata[AMC_W-1:0];
      end
   end

   always_comb begin
      status_word               = '0;
      status_word[BIT_SIGN_RE]  = sign_real_flag_q;
      status_word[BIT_SIGN_IM]  = sign_imag_flag_q;
      status_word[BIT_CARRY_RE] = carry_real_flag_q;
      status_word[BIT_CARRY_IM] = carry_imag_flag_q;
      status_word[BIT_ZERO]     = zero_flag_q;
      status_word[BIT_OVF]      = overflow_flag_q;
      status_word[BIT_STICKY]   = sticky_overflow_flag_q;
      status_word[BIT_EARLY]    = early_overflow_flag_q;
      status_word[BIT_MUL_OVF]  = multiplier_overflow_flag_q;
      status_word[BIT_VACANT]   = queue_vacant_flag_q;
      status_word[BIT_CLAMP]    = clamp_enable_q;
      status_word[BIT_MODE_HI:BIT_MODE_LO] = mode_q;
      status_word[BIT_X_WRAP]   = x_wrap_q;
      status_word[BIT_Y_WRAP]   = y_wrap_q;
   end

   always_comb begin
      read_mux = '0;
      case (address)
         OFF_STATUS:      read_mux[15:0]      = status_word;
         OFF_ACCESS_MODE: read_mux[AMC_W-1:0] = amc_q;
         OFF_RESULT:      read_mux            = alu_result_out;
         default:         read_mux            = '0;
      endcase
   end

   // read data captured on the request edge, standing while waitrequest is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata_q <= '0;
      end else if (read && bus_state_q == BUS_IDLE) begin
         readdata_q <= read_mux;
      end
   end

   // saturation applies per lane, never in double precision
   assign clamp_lo_on = clamp_enable_q && !is_double;
   assign clamp_hi_on = clamp_enable_q && is_complex;

   result_clamp_lane #(
      .W (RES_W)
   ) u_lane_lo (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (alu_valid),
      .clamp_on  (clamp_lo_on),
      .ovf       (alu_ovf_lo),
      .value     (alu_result[RES_W-1:0]),
      .pos_limit (CLAMP_POS),
      .neg_limit (CLAMP_NEG),
      .result_q  (clamped_lo)
   );

   result_clamp_lane #(
      .W (RES_W)
   ) u_lane_hi (
      .clk       (clk),
      .rst_n     (rst_n),
      .load      (alu_valid),
      .clamp_on  (clamp_hi_on),
      .ovf       (alu_ovf_hi),
      .value     (alu_result[2*RES_W-1:RES_W]),
      .pos_limit (CLAMP_POS),
      .neg_limit (CLAMP_NEG),
      .result_q  (clamped_hi)
   );

   // outputs, all from flops
   assign alu_result_out        = {clamped_hi, clamped_lo};
   assign readdata              = readdata_q;
   assign waitrequest           = waitrequest_q;
   assign processor_status_word = status_word;
   assign arith_mode            = mode_q;
   assign clamp_enable          = clamp_enable_q;
   assign x_bank_wrap_flag      = x_wrap_q;
   assign y_bank_wrap_flag      = y_wrap_q;
   assign access_mode_control   = amc_q;
endmodule

// >>> hw/status_word_pkg.sv
// constants for the processor status word bank
package status_word_pkg;
   localparam int         DATA_W          = 16;
   localparam int         BUS_W           = 32;
   localparam int         ADDR_W          = 4;
   localparam int         AMC_W           = 7;

   localparam logic [3:0] OFF_STATUS      = 4'h0;
   localparam logic [3:0] OFF_ACCESS_MODE = 4'h4;
   localparam logic [3:0] OFF_RESULT      = 4'h8;

   localparam int         BIT_SIGN_RE     = 15;
   localparam int         BIT_SIGN_IM     = 14;
   localparam int         BIT_CARRY_RE    = 13;
   localparam int         BIT_CARRY_IM    = 12;
   localparam int         BIT_ZERO        = 11;
   localparam int         BIT_OVF         = 10;
   localparam int         BIT_STICKY      = 9;
   localparam int         BIT_EARLY       = 8;
   localparam int         BIT_MUL_OVF     = 7;
   localparam int         BIT_VACANT      = 6;
   localparam int         BIT_CLAMP       = 5;
   localparam int         BIT_MODE_HI     = 4;
   localparam int         BIT_MODE_LO     = 3;
   localparam int         BIT_X_WRAP      = 2;
   localparam int         BIT_Y_WRAP      = 1;

   localparam logic [1:0] MODE_REAL       = 2'h1;
   localparam logic [1:0] MODE_COMPLEX    = 2'h3;
   localparam logic [1:0] MODE_DOUBLE     = 2'h2;

   localparam logic [15:0] STATUS_RESET   = 16'h0008;
   localparam logic [6:0]  AMC_RESET      = 7'h00;
   localparam logic [15:0] CLAMP_POS      = 16'h7FFF;
   localparam logic [15:0] CLAMP_NEG      = 16'h8000;

   typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// >>> hw/result_clamp_lane.sv
// one lane of result saturation with registered output
`timescale 1ns/1ps
module result_clamp_lane #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic         clamp_on,
   input  wire logic         ovf,
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] pos_limit,
   input  wire logic [W-1:0] neg_limit,
   output logic      [W-1:0] result_q
);
   // a wrapped sum carries the wrong sign: negative top bit means positive overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= '0;
      end else if (load) begin
         if (clamp_on && ovf && value[W-1]) begin
            result_q <= pos_limit;
         end else if (clamp_on && ovf) begin
            result_q <= neg_limit;
         end else begin
            result_q <= value;
         end
      end
   end
endmodule

// >>> test/dsp_status_flag_register_properties.sv
// checker for the status word bank, bound to its ports
`timescale 1ns/1ps
module status_word_checker
   import status_word_pkg::*;
#(
   parameter int RES_W = status_word_pkg::DATA_W
) (
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               read,
   input wire logic               write,
   input wire logic [ADDR_W-1:0]  address,
   input wire logic [3:0]         byteenable,
   input wire logic [BUS_W-1:0]   writedata,
   input wire logic               waitrequest,
   input wire logic               alu_valid,
   input wire logic [2*RES_W-1:0] alu_result,
   input wire logic               alu_ovf_lo,
   input wire logic               alu_ovf_hi,
   input wire logic               mul_ovf,
   input wire logic               branch_tests_sticky,
   input wire logic               load_condition_instruction,
   input wire logic               fifo_empty,
   input wire logic [2*RES_W-1:0] alu_result_out,
   input wire logic [15:0]        processor_status_word,
   input wire logic [1:0]         arith_mode,
   input wire logic               clamp_enable,
   input wire logic               x_bank_wrap_flag,
   input wire logic               y_bank_wrap_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_sign_real: assert property (alu_valid && !load_condition_instruction && !alu_ovf_lo
      && arith_mode != MODE_DOUBLE |=> processor_status_word[15] == $past(alu_result[15]))
      else $error("sign flag does not follow result top bit");
   a_zero_complex: assert property (alu_valid && !load_condition_instruction
      && arith_mode == MODE_COMPLEX |=> processor_status_word[11] == ($past(alu_result) == '0))
      else $error("zero flag wrong in complex mode");
   a_ovf_either: assert property (alu_valid && !load_condition_instruction
      && arith_mode == MODE_COMPLEX |=> processor_status_word[10] == $past(alu_ovf_lo || alu_ovf_hi))
      else $error("overflow flag wrong in complex mode");
   a_sticky_hold: assert property ($fell(processor_status_word[9]) |-> $past(branch_tests_sticky))
      else $error("sticky overflow cleared without branch test");
   a_early_set: assert property (alu_valid && arith_mode != MODE_DOUBLE
      && (alu_result[14] ^ alu_result[15]) |=> processor_status_word[8])
      else $error("early overflow not set");
   a_early_hold: assert property ($fell(processor_status_word[8]) |-> $past(load_condition_instruction))
      else $error("early overflow cleared without load-condition");
   a_mul_ovf: assert property (mul_ovf && arith_mode == MODE_COMPLEX |=> processor_status_word[7])
      else $error("multiplier overflow not latched");
   a_queue_vacant: assert property (1'b1 |=> processor_status_word[6] == $past(fifo_empty))
      else $error("queue vacant flag does not track fifo");
   a_clamp_pos: assert property (alu_valid && clamp_enable && arith_mode == MODE_REAL
      && alu_ovf_lo && alu_result[15] |=> alu_result_out[15:0] == CLAMP_POS)
      else $error("positive overflow not clamped");
   a_clamp_neg: assert property (alu_valid && clamp_enable && arith_mode == MODE_REAL
      && alu_ovf_lo && !alu_result[15] |=> alu_result_out[15:0] == CLAMP_NEG)
      else $error("negative overflow not clamped");
   a_double_plain: assert property (alu_valid && arith_mode == MODE_DOUBLE
      |=> alu_result_out == $past(alu_result))
      else $error("double precision result altered");
   a_state_fields: assert property (processor_status_word[5:1] ==
      {clamp_enable, arith_mode, x_bank_wrap_flag, y_bank_wrap_flag})
      else $error("state outputs disagree with status word");
   a_state_write: assert property (write && !waitrequest && address == OFF_STATUS && byteenable[0]
      |=> processor_status_word[5:1] == $past(writedata[5:1]))
      else $error("state half does not take the written value");
   a_spare_zero: assert property (processor_status_word[0] == 1'b0)
      else $error("spare status bit not zero");
   a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");

   c_clamp: cover property (alu_valid && clamp_enable && alu_ovf_lo);
   c_branch: cover property (branch_tests_sticky && processor_status_word[9]);
   c_read: cover property (read && !waitrequest);
endmodule

bind dsp_status_flag_register status_word_checker #(.RES_W(RES_W)) chk (
   .clk, .rst_n, .read, .write, .address, .byteenable, .writedata, .waitrequest, .alu_valid, .alu_result,
   .alu_ovf_lo, .alu_ovf_hi,
   .mul_ovf, .branch_tests_sticky, .load_condition_instruction, .fifo_empty, .alu_result_out,
   .processor_status_word, .arith_mode, .clamp_enable, .x_bank_wrap_flag, .y_bank_wrap_flag);

// >>> test/alu_side_model.sv
// far-side model: alu, multiplier, branch logic and input fifo
`timescale 1ns/1ps
module alu_side_model (
   input  wire logic        clk,
   output logic             alu_valid,
   output logic [31:0]      alu_result,
   output logic             alu_carry_lo,
   output logic             alu_carry_hi,
   output logic             alu_ovf_lo,
   output logic             alu_ovf_hi,
   output logic             mul_ovf,
   output logic             branch_tests_sticky,
   output logic             load_condition_instruction,
   output logic [7:0]       load_condition_data,
   output logic             fifo_empty
);
   initial begin
      {alu_valid, alu_carry_lo, alu_carry_hi, alu_ovf_lo, alu_ovf_hi} = 5'h00;
      {mul_ovf, branch_tests_sticky, load_condition_instruction, fifo_empty} = 4'h0;
      alu_result = 32'h0;
      load_condition_data = 8'h00;
   end
   // one result; flags given as {ovf_hi, ovf_lo, carry_hi, carry_lo}
   task automatic post(input logic [31:0] r, input logic [3:0] f);
      @(posedge clk);
      alu_valid <= 1'b1;
      alu_result <= r;
      {alu_ovf_hi, alu_ovf_lo, alu_carry_hi, alu_carry_lo} <= f;
      @(posedge clk);
      alu_valid <= 1'b0;
      alu_result <= ~r;
      {alu_ovf_hi, alu_ovf_lo, alu_carry_hi, alu_carry_lo} <= 4'h0;
      #1;
   endtask
   // event pulse as {multiplier, branch, load-condition}
   task automatic pulse(input logic [2:0] e, input logic [7:0] d);
      @(posedge clk);
      {mul_ovf, branch_tests_sticky, load_condition_instruction} <= e;
      load_condition_data <= d;
      @(posedge clk);
      {mul_ovf, branch_tests_sticky, load_condition_instruction} <= 3'h0;
      load_condition_data <= ~d;
      #1;
   endtask
   task automatic fifo(input logic e);
      @(posedge clk);
      fifo_empty <= e;
      @(posedge clk);
      #1;
   endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the status word bank
`timescale 1ns/1ps
module testbench;
   import status_word_pkg::*;
   logic        clk, rst_n, read, write, waitrequest, alu_valid, alu_carry_lo, alu_carry_hi;
   logic        alu_ovf_lo, alu_ovf_hi, mul_ovf, branch_tests_sticky, load_condition_instruction;
   logic        fifo_empty, clamp_enable, x_bank_wrap_flag, y_bank_wrap_flag;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata, alu_result, alu_result_out;
   logic [7:0]  load_condition_data;
   logic [15:0] processor_status_word;
   logic [1:0]  arith_mode;
   logic [6:0]  access_mode_control;
   logic [1:0]  modes[3] = '{MODE_REAL, MODE_DOUBLE, MODE_COMPLEX};
   int          n_mismatch, check_count;

   alu_side_model far (.clk, .alu_valid, .alu_result, .alu_carry_lo, .alu_carry_hi, .alu_ovf_lo,
      .alu_ovf_hi, .mul_ovf, .branch_tests_sticky, .load_condition_instruction, .load_condition_data, .fifo_empty);
   dsp_status_flag_register dut (.clk, .rst_n, .address, .read, .write, .byteenable, .writedata, .readdata,
      .waitrequest, .alu_valid, .alu_result, .alu_carry_lo, .alu_carry_hi, .alu_ovf_lo, .alu_ovf_hi, .mul_ovf,
      .branch_tests_sticky, .load_condition_instruction, .load_condition_data, .fifo_empty, .alu_result_out,
      .processor_status_word, .arith_mode, .clamp_enable, .x_bank_wrap_flag, .y_bank_wrap_flag,
      .access_mode_control);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= wd;
      read <= !we;
      write <= we;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 40) begin
         n_mismatch++;
         give_verdict();
      end
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(x, e, "readdata");
   endtask

   task automatic ps(input logic [15:0] e);
      check({16'h0, processor_status_word}, {16'h0, e}, "status");
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {rst_n, read, write} = 3'h0;
      address = 4'h0;
      byteenable = 4'hF;
      writedata = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdc(OFF_STATUS, {16'h0, STATUS_RESET});
      rdc(OFF_ACCESS_MODE, {25'h0, AMC_RESET});
      wr(OFF_ACCESS_MODE, 32'h7F);
      rdc(OFF_ACCESS_MODE, 32'h7F);
      check({25'h0, access_mode_control}, 32'h7F, "access mode port");
      wr(4'hC, 32'hFFFF);
      rdc(4'hC, 32'h0);
      wr(OFF_STATUS, 32'hFFFF);
      rdc(OFF_STATUS, 32'h3E);
      check({27'h0, clamp_enable, arith_mode, x_bank_wrap_flag, y_bank_wrap_flag}, 32'h1F, "state");
      foreach (modes[i]) begin
         wr(OFF_STATUS, {27'h0, modes[i], 3'h0});
         check({30'h0, arith_mode}, {30'h0, modes[i]}, "mode");
      end
      $display("test registers done");
      far.post(32'h8000_0001, 4'h2);
      ps(16'h5018);
      far.post(32'h0001_0000, 4'h0);
      ps(16'h0018);
      far.post(32'h0000_0000, 4'h0);
      ps(16'h0818);
      far.post(32'h0000_0001, 4'h8);
      ps(16'h0618);
      far.post(32'h0000_0001, 4'h0);
      ps(16'h0218);
      far.pulse(3'b010, 8'h00);
      ps(16'h0018);
      far.post(32'h0000_4000, 4'h0);
      far.post(32'h0000_0001, 4'h0);
      ps(16'h0118);
      far.pulse(3'b100, 8'h00);
      ps(16'h0198);
      far.pulse(3'b001, 8'hA8);
      ps(16'hA818);
      $display("test complex flags done");
      wr(OFF_STATUS, 32'h08);
      far.pulse(3'b100, 8'h00);
      ps(16'hA808);
      far.post(32'h0000_8000, 4'h1);
      ps(16'hA108);
      far.post(32'hFFFF_0000, 4'h0);
      ps(16'h0908);
      far.fifo(1'b1);
      ps(16'h0948);
      far.fifo(1'b0);
      ps(16'h0908);
      $display("test real flags done");
      wr(OFF_STATUS, 32'h28);
      far.post(32'h0000_8001, 4'h4);
      check({16'h0, alu_result_out[15:0]}, {16'h0, CLAMP_POS}, "result");
      far.post(32'h0000_7FFE, 4'h4);
      check({16'h0, alu_result_out[15:0]}, {16'h0, CLAMP_NEG}, "result");
      wr(OFF_STATUS, 32'h30);
      far.post(32'h1234_8001, 4'hC);
      check(alu_result_out, 32'h1234_8001, "result");
      rdc(OFF_RESULT, 32'h1234_8001);
      $display("test clamping done");
      give_verdict();
   end
endmodule
